/* File: hdl/smbus_block_write.sv */
// SMBus index block write target feeding configuration storage.
`timescale 1ns/100ps
module smbus_block_write
    import smbus_write_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // SMBus pins; data is open drain.
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Reference input clock, watched for activity.
    input wire logic refClkIn,
    // Configuration storage write port.
    output logic cfgWrite,
    output logic [7:0] cfgIndex,
    output logic [7:0] cfgData,
    input wire logic cfgReady,
    // Status.
    output logic refActive
);
    logic [2:0] sclSync_reg, sdaSync_reg, refSync_reg;
    logic sclRise, sclFall, startSeen, stopSeen, refEdge;
    phase_t phase_reg, phase_next;
    logic [2:0] bitCnt_reg, bitCnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [7:0] remain_reg, remain_next;
    logic ackSlot_reg, ackSlot_next;
    logic sdaOe_reg, sdaOe_next;
    logic pushValid_reg, pushValid_next;
    logic [15:0] pushData_reg, pushData_next;
    logic [15:0] refCnt_reg, refCnt_next;
    logic refActive_reg, refActive_next;
    logic fifoReady, fifoValid;
    logic [15:0] fifoData;
    logic wrValid_reg, wrValid_next;
    logic [15:0] wrWord_reg, wrWord_next;

    // -------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sclSync_reg <= 3'h7;
            sdaSync_reg <= 3'h7;
            refSync_reg <= 3'h0;
        end
        else
        begin
            sclSync_reg <= {sclSync_reg[1:0], sclIn};
            sdaSync_reg <= {sdaSync_reg[1:0], sdaIn};
            refSync_reg <= {refSync_reg[1:0], refClkIn};
        end
    end

    // Only stages 1 and 2 are looked at; stage 0 feeds stage 1 alone.
    assign sclRise = sclSync_reg[1] && !sclSync_reg[2];
    assign sclFall = !sclSync_reg[1] && sclSync_reg[2];
    assign startSeen = sclSync_reg[1] && sdaSync_reg[2] && !sdaSync_reg[1];
    assign stopSeen = sclSync_reg[1] && !sdaSync_reg[2] && sdaSync_reg[1];
    assign refEdge = refSync_reg[1] != refSync_reg[2];

    // -------------------------------------------------------------------
    // Reference clock activity
    // -------------------------------------------------------------------
    always_comb
    begin
        refCnt_next = refCnt_reg;
        refActive_next = refActive_reg;
        if (refEdge)
        begin
            refCnt_next = '0;
            refActive_next = 1'b1; // RL9
        end
        else if (refCnt_reg == 16'(REF_TIMEOUT_CYC))
        begin
            refActive_next = 1'b0; // RL9
        end
        else
        begin
            refCnt_next = refCnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            refCnt_reg <= '0;
            refActive_reg <= 1'b0;
        end
        else
        begin
            refCnt_reg <= refCnt_next;
            refActive_reg <= refActive_next;
        end
    end

    // -------------------------------------------------------------------
    // Byte engine
    // -------------------------------------------------------------------
    // Bits are taken on SCL rise, which leaves ample margin at 400 kHz
    // against a 40 MHz sampler. RL11
    always_comb
    begin
        phase_next = phase_reg;
        bitCnt_next = bitCnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        remain_next = remain_reg;
        ackSlot_next = ackSlot_reg;
        sdaOe_next = sdaOe_reg;
        pushValid_next = 1'b0;
        pushData_next = pushData_reg;
        if (!refActive_reg || stopSeen)
        begin
            phase_next = IDLE; // RL9 RL13
            sdaOe_next = 1'b0;
            ackSlot_next = 1'b0;
        end
        else if (startSeen)
        begin
            phase_next = ADDR; // RL13
            bitCnt_next = '0;
            // A stale byte would pass for a finished address at the
            // first SCL fall after a start, so the shifter starts empty.
            shift_next = 8'h00;
            sdaOe_next = 1'b0;
            ackSlot_next = 1'b0;
        end
        else if (phase_reg != IDLE && phase_reg != IGNORE)
        begin
            if (sclRise && !ackSlot_reg)
            begin
                shift_next = {shift_reg[6:0], sdaSync_reg[2]};
                bitCnt_next = bitCnt_reg + 3'h1;
            end
            else if (sclFall && !ackSlot_reg && bitCnt_reg == '0 &&
                     shift_reg != 8'h00 || sclFall && !ackSlot_reg &&
                     bitCnt_reg == '0 && phase_reg != ADDR)
            begin
                ackSlot_next = 1'b1;
                sdaOe_next = 1'b1;
                unique case (phase_reg)
                    ADDR:
                    begin
                        if (shift_reg == {TARGET_ADDR, 1'b0}) // RL10
                        begin
                            phase_next = INDEX; // RL3
                        end
                        else
                        begin
                            phase_next = IGNORE; // RL13
                            sdaOe_next = 1'b0;
                            ackSlot_next = 1'b0;
                        end
                    end
                    INDEX:
                    begin
                        ptr_next = shift_reg; // RL4
                        phase_next = COUNT;
                    end
                    COUNT:
                    begin
                        remain_next = shift_reg; // RL5
                        phase_next = DATA;
                    end
                    DATA:
                    begin
                        // Bytes past the count are refused by NACK. RL6
                        if (remain_reg != 8'h00 && fifoReady)
                        begin
                            pushValid_next = 1'b1; // RL7
                            pushData_next = {ptr_reg, shift_reg};
                            ptr_next = ptr_reg + 8'h01; // RL12
                            remain_next = remain_reg - 8'h01;
                        end
                        else
                        begin
                            sdaOe_next = 1'b0;
                        end
                    end
                    default:
                    begin
                        phase_next = IDLE;
                    end
                endcase
            end
            else if (sclFall && ackSlot_reg)
            begin
                ackSlot_next = 1'b0;
                sdaOe_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase_reg <= IDLE;
            bitCnt_reg <= '0;
            shift_reg <= 8'h00;
            ptr_reg <= INDEX_RESET;
            remain_reg <= 8'h00;
            ackSlot_reg <= 1'b0;
            sdaOe_reg <= 1'b0;
            pushValid_reg <= 1'b0;
            pushData_reg <= 16'h0000;
        end
        else
        begin
            phase_reg <= phase_next;
            bitCnt_reg <= bitCnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            remain_reg <= remain_next;
            ackSlot_reg <= ackSlot_next;
            sdaOe_reg <= sdaOe_next;
            pushValid_reg <= pushValid_next;
            pushData_reg <= pushData_next;
        end
    end

    // -------------------------------------------------------------------
    // Buffer toward the configuration storage
    // -------------------------------------------------------------------
    byte_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) fifo (
        .clk(clk),
        .nrst(nrst),
        .inValid(pushValid_reg),
        .inReady(fifoReady),
        .inData(pushData_reg),
        .outValid(fifoValid),
        .outReady(!wrValid_reg || cfgReady),
        .outData(fifoData)
    );

    always_comb
    begin
        wrValid_next = wrValid_reg;
        wrWord_next = wrWord_reg;
        if (!wrValid_reg || cfgReady)
        begin
            wrValid_next = fifoValid;
            wrWord_next = fifoData;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrValid_reg <= 1'b0;
            wrWord_reg <= 16'h0000;
        end
        else
        begin
            wrValid_reg <= wrValid_next;
            wrWord_reg <= wrWord_next;
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_reg;
    assign cfgWrite = wrValid_reg;
    assign cfgIndex = wrWord_reg[15:8];
    assign cfgData = wrWord_reg[7:0];
    assign refActive = refActive_reg;
endmodule : smbus_block_write

/* File: hdl/smbus_write_pkg.sv */
// Constants and types shared by the SMBus block write target.
// Summary of operation
// RL1: Host opens each transaction with a start condition.
// RL2: Host sends seven-bit target address with write direction after start.
// RL3: Device acknowledges its own address when the direction bit is write.
// RL4: Index byte N is acknowledged and becomes the first location written.
// RL5: Byte count X follows the index and is acknowledged.
// RL6: Host sends exactly X data bytes for locations N to N+X-1.
// RL7: Device acknowledges every data byte in its own acknowledge slot; the code refuses a data byte while the buffer is full.
// RL8: Host ends the block write with a stop condition.
// RL9: Port responds only while the reference input clock toggles.
// RL10: Device answers the target address 1101101 plus direction bit.
// RL11: Port works at bus clock rates up to 400 kHz.
// RL12: Location pointer advances by one after each data byte.
// RL13: Foreign addresses are ignored; stop or stray start returns to idle; the code sends a start back to address reception.
package smbus_write_pkg;
    localparam logic [6:0] TARGET_ADDR = 7'h6D;
    localparam int CLK_MHZ = 40;
    localparam int REF_TIMEOUT_NS = 1000;
    localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS * CLK_MHZ) / 1000;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [2:0] {
        IDLE, ADDR, INDEX, COUNT, DATA, IGNORE
    } phase_t;
endpackage : smbus_write_pkg

/* File: hdl/byte_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Filling side.
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side.
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [AW:0] count_reg, count_next;
    logic push, pop;

    assign inReady = (count_reg != FULL_COUNT);
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb
    begin
        wrPtr_next = wrPtr_reg;
        rdPtr_next = rdPtr_reg;
        count_next = count_reg;
        if (push)
        begin
            wrPtr_next = (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
        end
        if (pop)
        begin
            rdPtr_next = (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
        end
        if (push && !pop)
        begin
            count_next = count_reg + 1'b1;
        end
        else if (pop && !push)
        begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
        end
    end

    // Storage has no reset; only the pointers and the count define what is valid.
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wrPtr_reg] <= inData;
        end
    end
endmodule : byte_fifo

/* File: test/smbus_host_model.sv */
// Behavioural SMBus host that drives block write frames.
`timescale 1ns/100ps
module smbus_host_model (
    // Clock.
    input wire logic clk,
    // Bus.
    input wire logic sdaOe,
    output logic scl,
    output logic sdaLine
);
    logic sdaDrv = 1'b1;

    // The data line has a pull-up, so it is low while either party pulls.
    assign sdaLine = sdaDrv & ~sdaOe;

    initial scl = 1'b1;

    task automatic q(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : q

    // Data moves two cycles after a clock edge, so it never races SCL.
    task automatic bit2(input logic s, input logic c);
        q(2);
        sdaDrv = s;
        q(2);
        scl = c;
    endtask : bit2

    task automatic start();
        bit2(1'b1, 1'b1);
        bit2(1'b0, 1'b0);
    endtask : start

    task automatic stop();
        bit2(1'b0, 1'b1);
        bit2(1'b1, 1'b1);
    endtask : stop

    task automatic sendByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            bit2(b[i], 1'b1);
            bit2(b[i], 1'b0);
        end
        bit2(1'b1, 1'b1);
        q(3);
        ack = ~sdaLine;
        bit2(1'b1, 1'b0);
    endtask : sendByte
endmodule : smbus_host_model

/* File: test/smbus_write_checker.sv */
// Port assertions for the SMBus block write target.
`timescale 1ns/100ps
module smbus_write_checker
    import smbus_write_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Bus and reference clock.
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic refClkIn,
    // Storage port and status.
    input wire logic cfgWrite,
    input wire logic [7:0] cfgIndex,
    input wire logic [7:0] cfgData,
    input wire logic cfgReady,
    input wire logic refActive
);
    localparam int QUIET_MAX = REF_TIMEOUT_CYC + 8;
    logic [7:0] quiet_reg, quiet_next;
    logic refPrev_reg, refPrev_next;

    always_comb
    begin
        refPrev_next = refClkIn;
        quiet_next = quiet_reg + ((quiet_reg == 8'hFF) ? 8'h00 : 8'h01);
        if (refClkIn != refPrev_reg)
            quiet_next = 8'h00;
    end

    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            quiet_reg <= 8'h00;
            refPrev_reg <= 1'b0;
        end
        else
        begin
            quiet_reg <= quiet_next;
            refPrev_reg <= refPrev_next;
        end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    drain_low_a: assert property (sdaOut == 1'b0)
        else $error("data output not held low");
    ack_length_a: assert property ($rose(sdaOe) |-> sdaOe [*4] ##[1:40] !sdaOe)
        else $error("acknowledge length wrong");
    ack_hold_a: assert property (sdaOe && sclIn |=> sdaOe)
        else $error("acknowledge dropped while clock high");
    ack_scl_low_a: assert property ($rose(sdaOe) |-> !sclIn)
        else $error("acknowledge raised while clock high");
    ack_ref_a: assert property ($rose(sdaOe) |-> refActive)
        else $error("acknowledge without reference clock");
    ref_idle_a: assert property (!refActive [*3] |-> !sdaOe)
        else $error("bus driven while reference stopped");
    ref_timeout_a: assert property (quiet_reg > QUIET_MAX |-> !refActive)
        else $error("reference activity kept after timeout");
    ref_drop_a: assert property ($fell(refActive) |-> quiet_reg > 8)
        else $error("reference activity dropped too early");
    write_hold_a: assert property (cfgWrite && !cfgReady |=> cfgWrite &&
        $stable(cfgIndex) && $stable(cfgData))
        else $error("write request changed before accept");
endmodule : smbus_write_checker

bind smbus_block_write smbus_write_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
    .clk(clk), .nrst(nrst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .refClkIn(refClkIn), .cfgWrite(cfgWrite),
    .cfgIndex(cfgIndex), .cfgData(cfgData), .cfgReady(cfgReady),
    .refActive(refActive));

/* File: test/smbus_block_write_bench.sv */
// Self-checking bench for the SMBus block write target.
`timescale 1ns/100ps
module smbus_block_write_bench;
    import smbus_write_pkg::*;
    localparam logic [7:0] WADDR = {TARGET_ADDR, 1'b0};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic refClkIn = 1'b0;
    logic refRun = 1'b1;
    logic cfgReady = 1'b1;
    logic sdaOut, sdaOe, cfgWrite, refActive, scl, sdaLine;
    logic [7:0] cfgIndex, cfgData;
    logic [15:0] wq[$];
    int miscompares = 0;
    int compares = 0;

    initial forever #12.5 clk = ~clk;
    initial forever #50 refClkIn = refRun ? ~refClkIn : refClkIn;

    smbus_host_model host (.clk(clk), .sdaOe(sdaOe), .scl(scl),
        .sdaLine(sdaLine));
    smbus_block_write #(.FIFO_DEPTH(4)) uut (.clk(clk), .nrst(nrst),
        .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .refClkIn(refClkIn), .cfgWrite(cfgWrite), .cfgIndex(cfgIndex),
        .cfgData(cfgData), .cfgReady(cfgReady), .refActive(refActive));

    // Storage side accepts on any rising clock edge where request and ready meet.
    always @(posedge clk)
        if (cfgWrite === 1'b1 && cfgReady === 1'b1)
            wq.push_back({cfgIndex, cfgData});

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("Compares %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    function automatic logic [7:0] dat(input int k);
        return 8'(8'h5A + 8'h11 * k);
    endfunction : dat

    task automatic waitRef(input logic lvl);
        int i;
        for (i = 0; i < 200 && refActive !== lvl; i++)
            @(posedge clk);
        #1;
        check(16'(refActive), 16'(lvl));
        if (i == 200)
            wrap_up();
    endtask : waitRef

    task automatic checkWrites(input logic [7:0] n, input int cnt);
        int i;
        for (i = 0; i < 400 && wq.size() < cnt; i++)
            @(posedge clk);
        check(16'(wq.size()), 16'(cnt));
        if (i == 400)
            wrap_up();
        for (int k = 0; k < cnt; k++)
            check(wq.pop_front(), {8'(n + k), dat(k)});
    endtask : checkWrites

    // Bytes go out as address, index, count, then data; the ack of
    // byte i lands in bit i of acks.
    task automatic xfer(input logic [7:0] a, input logic [7:0] n,
        input logic [7:0] x, input int cnt, input bit doStop,
        output logic [15:0] acks);
        logic ack;
        logic [7:0] b;
        acks = 16'h0000;
        host.start();
        for (int i = 0; i < cnt + 3; i++)
        begin
            b = (i == 0) ? a : (i == 1) ? n : (i == 2) ? x : dat(i - 3);
            host.sendByte(b, ack);
            acks[i] = ack;
        end
        if (doStop)
            host.stop();
    endtask : xfer

    task automatic testBasic();
        logic [15:0] acks;
        xfer(WADDR, 8'hFE, 8'h03, 3, 1, acks);
        check(acks, 16'h003F);
        checkWrites(8'hFE, 3);
        $display("basic write with index wrap done");
    endtask : testBasic

    task automatic testForeign();
        logic [15:0] acks;
        xfer(WADDR ^ 8'h02, 8'h10, 8'h01, 1, 1, acks);
        check(acks, 16'h0000);
        check(16'(wq.size()), 16'h0000);
        $display("foreign address done");
    endtask : testForeign

    task automatic testRestart();
        logic [15:0] acks;
        xfer(WADDR, 8'h20, 8'h02, 1, 0, acks);
        check(acks, 16'h000F);
        checkWrites(8'h20, 1);
        xfer(WADDR, 8'h40, 8'h01, 2, 1, acks);
        check(acks, 16'h000F);
        checkWrites(8'h40, 1);
        $display("repeated start and excess byte done");
    endtask : testRestart

    // Four buffer entries plus the output stage hold bytes while the
    // storage stalls; the sixth data byte must be refused.
    task automatic testStall();
        logic [15:0] acks;
        int m;
        @(posedge clk);
        #1;
        cfgReady = 1'b0;
        xfer(WADDR, 8'h80, 8'h06, 6, 1, acks);
        check(acks & 16'h007F, 16'h007F);
        check(16'(acks[8]), 16'h0000);
        m = $countones(acks[8:3]);
        check(16'(m), 16'h0005);
        check(16'(acks[8:3]), 16'((1 << m) - 1));
        cfgReady = 1'b1;
        checkWrites(8'h80, m);
        $display("storage stall done");
    endtask : testStall

    task automatic testRefStop();
        logic [15:0] acks;
        refRun = 1'b0;
        waitRef(1'b0);
        xfer(WADDR, 8'h00, 8'h00, 0, 1, acks);
        check(acks, 16'h0000);
        refRun = 1'b1;
        waitRef(1'b1);
        $display("stopped reference done");
    endtask : testRefStop

    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
        waitRef(1'b1);
        testBasic();
        testForeign();
        testRestart();
        testStall();
        testRefStop();
        wrap_up();
    end
endmodule : smbus_block_write_bench
